//--- include/pps_pkg.sv
package pps_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] TARGET_SECONDS_OFS = 12'h71c;
   localparam logic [11:0] TARGET_SUBSECONDS_OFS = 12'h720;
   localparam logic [11:0] TIME_SYNC_STATUS_OFS = 12'h728;
   localparam logic [11:0] PULSE_OUTPUT_CONTROL_OFS = 12'h72c;
   localparam logic [11:0] EVENT_STATUS_OFS = 12'h730;
   localparam logic [11:0] EVENT_MASK_OFS = 12'h734;

   // ------------------------------------------------------------
   // Field positions and widths
   // ------------------------------------------------------------
   localparam int SECONDS_WRAP_BIT = 0;
   localparam int TARGET_HIT_BIT = 1;
   localparam int FLAG_W = 2;
   localparam int RATE_W = 4;
   localparam int SUBSEC_W = 31;
   localparam int SUBSEC_TOP = 30;

   // ------------------------------------------------------------
   // Reset values and seconds limit
   // ------------------------------------------------------------
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 2'h0;
   localparam logic [RATE_W-1:0] RATE_RESET = 4'h0;
   localparam logic [31:0] SECONDS_MAX = 32'hffff_ffff;

   // ------------------------------------------------------------
   // One-hertz pulse width
   // ------------------------------------------------------------
   localparam int BIN_HIGH_MS = 125;
   localparam int DIG_HIGH_MS = 100;
   localparam longint MS_PER_S = 1000;
   localparam longint DIG_NS_PER_MS = 1000000;
   // Binary rollover: 2^31 counts make one second
   localparam longint BIN_COUNTS_PER_S = 64'h0000_0000_8000_0000;
   localparam logic [SUBSEC_W-1:0] BIN_HIGH_COUNT =
      SUBSEC_W'((BIN_COUNTS_PER_S * BIN_HIGH_MS) / MS_PER_S);
   // Digital rollover: one count per nanosecond
   localparam logic [SUBSEC_W-1:0] DIG_HIGH_COUNT =
      SUBSEC_W'(DIG_HIGH_MS * DIG_NS_PER_MS);

   // Full system time at or past the target
   function automatic logic time_ge(input logic [31:0] sec, input logic [SUBSEC_W-1:0] sub,
                                    input logic [31:0] tsec, input logic [SUBSEC_W-1:0] tsub);
      time_ge = {sec, sub} >= {tsec, tsub};
   endfunction : time_ge
endpackage : pps_pkg

//--- rtl/pps_pulse_gen.sv
module pps_pulse_gen (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Time base
   input wire logic [30:0] system_subseconds,
   input wire logic digital_rollover,
   input wire logic [3:0] pulse_rate_select,
   // Pulse
   output logic pps_out
);
   logic pps_reg;
   logic pps_next;
   logic [4:0] bit_idx;

   // ------------------------------------------------------------
   // Pulse level
   // ------------------------------------------------------------
   always_comb begin
      pps_next = 1'b0;
      bit_idx = 5'h00;
      if (pulse_rate_select == 4'h0) begin
         // R4 one hertz
         if (digital_rollover) begin
            pps_next = system_subseconds < pps_pkg::DIG_HIGH_COUNT;
         end else begin
            pps_next = system_subseconds < pps_pkg::BIN_HIGH_COUNT;
         end
      end else begin
         // R3 power of two
         // Digital mode has no clean bit; rate comes out irregular
         if (digital_rollover) begin
            bit_idx = 5'(pps_pkg::SUBSEC_TOP - 1) - {1'b0, pulse_rate_select};
         end else begin
            // R5 binary half period
            bit_idx = 5'(pps_pkg::SUBSEC_TOP) - {1'b0, pulse_rate_select};
         end
         // R9 subsecond bit
         pps_next = system_subseconds[bit_idx];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pps_reg <= 1'b0;
      end else begin
         pps_reg <= pps_next;
      end
   end

   assign pps_out = pps_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_square_wave;
      @(posedge sys_clk) disable iff (reset)
      (pulse_rate_select != 4'h0 && !digital_rollover)
      |=> pps_out == $past(system_subseconds[5'(pps_pkg::SUBSEC_TOP)
         - {1'b0, pulse_rate_select}]);
   endproperty
   a_square_wave: assert property (p_square_wave) else $error("square wave bit wrong"); // R5

   property p_one_hz;
      @(posedge sys_clk) disable iff (reset)
      (pulse_rate_select == 4'h0) |=> pps_out == ($past(digital_rollover) ?
         $past(system_subseconds) < pps_pkg::DIG_HIGH_COUNT
         : $past(system_subseconds[30:28]) == 3'h0);
   endproperty
   a_one_hz: assert property (p_one_hz) else $error("one hertz width wrong"); // R4

   c_pps_rise: cover property (@(posedge sys_clk) disable iff (reset) $rose(pps_out));
endmodule : pps_pulse_gen

//--- rtl/ptp_time_status_pps_output.sv
// Behaviour
// R1 - Seconds wrapping past all ones sets status bit 0.
// R2 - Reaching or passing the target time sets status bit 1.
// R3 - Pulse rate is two to the power of control bits 3:0 hertz.
// R4 - Rate zero gives 1 Hz: 125 ms high binary, 100 ms digital.
// R5 - Nonzero rates in binary rollover give a 50 percent square wave.
// R6 - Software should keep 1 Hz when digital rollover is used.
// R7 - Target compare uses target seconds and subseconds together.
// R8 - Subseconds are 31 bits, about 0.46 ns per count.
// R9 - Rollover mode is an input; edges follow subsecond bit transitions.
module ptp_time_status_pps_output (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // System-time counter
   input wire logic [31:0] system_seconds,
   input wire logic [30:0] system_subseconds,
   input wire logic digital_rollover,
   // Outputs
   output logic pps_out,
   output logic irq
);
   logic [31:0] target_seconds_reg;
   logic [30:0] target_subseconds_reg;
   logic [3:0] pulse_rate_select_reg;
   logic [1:0] flags_reg;
   logic [1:0] flags_next;
   logic [1:0] mask_reg;
   logic [31:0] sec_prev_reg;
   logic hit_prev_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic irq_reg;
   logic hit_now;
   logic wrap_event;
   logic hit_event;
   logic [1:0] flag_clear;

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         target_seconds_reg <= pps_pkg::REG_RESET;
         target_subseconds_reg <= pps_pkg::REG_RESET[30:0];
      end else if (reg_write && reg_addr == pps_pkg::TARGET_SECONDS_OFS) begin
         target_seconds_reg <= reg_wdata;
      end else if (reg_write && reg_addr == pps_pkg::TARGET_SUBSECONDS_OFS) begin
         // R8 31-bit subseconds
         target_subseconds_reg <= reg_wdata[30:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pulse_rate_select_reg <= pps_pkg::RATE_RESET;
      end else if (reg_write && reg_addr == pps_pkg::PULSE_OUTPUT_CONTROL_OFS) begin
         // R3 rate field
         pulse_rate_select_reg <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_reg <= pps_pkg::FLAG_RESET;
      end else if (reg_write && reg_addr == pps_pkg::EVENT_MASK_OFS) begin
         mask_reg <= reg_wdata[1:0];
      end
   end

   // ------------------------------------------------------------
   // Event detection
   // ------------------------------------------------------------
   // R7 full compare
   assign hit_now = pps_pkg::time_ge(system_seconds, system_subseconds,
                                     target_seconds_reg, target_subseconds_reg);
   // R2 first reach
   // Edge, not level, so a cleared flag stays clear while time stays past target
   assign hit_event = hit_now && !hit_prev_reg;
   // R1 seconds wrap
   assign wrap_event = sec_prev_reg == pps_pkg::SECONDS_MAX && system_seconds == 32'h0000_0000;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sec_prev_reg <= pps_pkg::REG_RESET;
         hit_prev_reg <= 1'b0;
      end else begin
         sec_prev_reg <= system_seconds;
         hit_prev_reg <= hit_now;
      end
   end

   // ------------------------------------------------------------
   // Sticky flags and interrupt
   // ------------------------------------------------------------
   always_comb begin
      flag_clear = 2'h0;
      if (reg_write && reg_addr == pps_pkg::EVENT_STATUS_OFS) begin
         flag_clear = reg_wdata[1:0];
      end
      // Set wins over a clear in the same cycle
      flags_next = flags_reg & ~flag_clear;
      flags_next[pps_pkg::SECONDS_WRAP_BIT] = flags_next[pps_pkg::SECONDS_WRAP_BIT] | wrap_event;
      flags_next[pps_pkg::TARGET_HIT_BIT] = flags_next[pps_pkg::TARGET_HIT_BIT] | hit_event;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flags_reg <= pps_pkg::FLAG_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(flags_reg & mask_reg);
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (reg_addr)
         pps_pkg::TARGET_SECONDS_OFS: rdata_next = target_seconds_reg;
         pps_pkg::TARGET_SUBSECONDS_OFS: rdata_next = {1'b0, target_subseconds_reg};
         pps_pkg::TIME_SYNC_STATUS_OFS: rdata_next = {30'h0, flags_reg};
         pps_pkg::PULSE_OUTPUT_CONTROL_OFS: rdata_next = {28'h0, pulse_rate_select_reg};
         pps_pkg::EVENT_STATUS_OFS: rdata_next = {30'h0, flags_reg};
         pps_pkg::EVENT_MASK_OFS: rdata_next = {30'h0, mask_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_reg <= pps_pkg::REG_RESET;
      end else if (reg_read) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq = irq_reg;

   // ------------------------------------------------------------
   // Pulse generator
   // ------------------------------------------------------------
   pps_pulse_gen u_pulse (
      .sys_clk(sys_clk),
      .reset(reset),
      .system_subseconds(system_subseconds),
      .digital_rollover(digital_rollover),
      .pulse_rate_select(pulse_rate_select_reg),
      .pps_out(pps_out)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_wrap_sets;
      @(posedge sys_clk) disable iff (reset)
      (system_seconds == 32'h0 && $past(system_seconds) == 32'hffff_ffff && !$past(reset))
      |=> flags_reg[0];
   endproperty
   a_wrap_sets: assert property (p_wrap_sets) else $error("wrap flag not set"); // R1

   property p_hit_sets;
      @(posedge sys_clk) disable iff (reset)
      $rose(hit_now) |=> flags_reg[1];
   endproperty
   a_hit_sets: assert property (p_hit_sets) else $error("target flag not set"); // R2

   property p_hit_cause;
      @(posedge sys_clk) disable iff (reset)
      $rose(flags_reg[1]) |-> $past(pps_pkg::time_ge(system_seconds, system_subseconds,
                                    target_seconds_reg, target_subseconds_reg));
   endproperty
   a_hit_cause: assert property (p_hit_cause) else $error("target flag without reach"); // R7

   property p_wrap_cause;
      @(posedge sys_clk) disable iff (reset)
      $rose(flags_reg[0]) |-> $past(system_seconds) == 32'h0000_0000
         && $past(sec_prev_reg) == pps_pkg::SECONDS_MAX;
   endproperty
   a_wrap_cause: assert property (p_wrap_cause) else $error("wrap flag without wrap"); // R1

   property p_rate_readback;
      @(posedge sys_clk) disable iff (reset)
      (reg_write && reg_addr == pps_pkg::PULSE_OUTPUT_CONTROL_OFS)
      ##1 (reg_read && reg_addr == pps_pkg::PULSE_OUTPUT_CONTROL_OFS && !reg_write)
      |=> reg_rdata == {28'h0, $past(reg_wdata[3:0], 2)};
   endproperty
   a_rate_readback: assert property (p_rate_readback) else $error("rate readback wrong"); // R3

   property p_subsec_width;
      @(posedge sys_clk) disable iff (reset)
      (reg_read && reg_addr == pps_pkg::TARGET_SUBSECONDS_OFS) |=> reg_rdata[31] == 1'b0;
   endproperty
   a_subsec_width: assert property (p_subsec_width) else $error("subsecond bit 31 set"); // R8

   property p_pps_follows;
      @(posedge sys_clk) disable iff (reset)
      ##2 $changed(pps_out) |-> $past(system_subseconds, 2) != $past(system_subseconds)
         || $past(pulse_rate_select_reg, 2) != $past(pulse_rate_select_reg)
         || $past(digital_rollover, 2) != $past(digital_rollover);
   endproperty
   a_pps_follows: assert property (p_pps_follows) else $error("pulse edge without cause"); // R9

   property p_irq_level;
      @(posedge sys_clk) disable iff (reset)
      !$past(reset) |-> irq == $past(|(flags_reg & mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong"); // R2

   c_wrap: cover property (@(posedge sys_clk) disable iff (reset) $rose(flags_reg[0]));
   c_hit: cover property (@(posedge sys_clk) disable iff (reset) $rose(flags_reg[1]));
   c_irq: cover property (@(posedge sys_clk) disable iff (reset) $rose(irq));
endmodule : ptp_time_status_pps_output

//--- tb/pps_monitor.sv
module pps_monitor (
   // Clock
   input wire logic sys_clk,
   // Pulse from the device
   input wire logic pps_out,
   // Observed activity
   output logic [15:0] rise_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pps_last_reg;

   initial begin
      rise_count = 16'h0;
      pps_last_reg = 1'b0;
   end

   // ------------------------------------------------------------
   // Edge counter
   // ------------------------------------------------------------
   // Counts only clean low-to-high steps, so an unknown level never scores
   always @(posedge sys_clk) begin
      if (pps_out === 1'b1 && pps_last_reg === 1'b0) begin
         rise_count <= rise_count + 16'h1;
      end
      pps_last_reg <= pps_out;
   end
endmodule : pps_monitor

//--- tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] reg_addr = 12'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] system_seconds = 32'h0;
   logic [30:0] system_subseconds = 31'h0;
   logic digital_rollover = 1'b0;
   logic pps_out;
   logic irq;
   logic [15:0] rise_count;
   int mismatches = 0;
   int compares = 0;

   always #5 sys_clk = ~sys_clk;

   ptp_time_status_pps_output ptp_time_status_pps_output_inst (.sys_clk(sys_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .system_seconds(system_seconds),
      .system_subseconds(system_subseconds), .digital_rollover(digital_rollover),
      .pps_out(pps_out), .irq(irq));
   pps_monitor pps_monitor_inst (.sys_clk(sys_clk), .pps_out(pps_out), .rise_count(rise_count));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_rd

   // Write then read with no gap between the strobes
   task automatic reg_wr_rd(input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask : reg_wr_rd

   task automatic step_sub(input logic [30:0] v);
      @(posedge sys_clk);
      system_subseconds <= v;
      @(posedge sys_clk);
      #1;
   endtask : step_sub

   task automatic set_sec(input logic [31:0] s, input logic [30:0] v);
      @(posedge sys_clk);
      system_seconds <= s;
      system_subseconds <= v;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : set_sec

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_reset;
      logic [31:0] d;
      reg_rd(pps_pkg::PULSE_OUTPUT_CONTROL_OFS, d);
      chk("control reset", d, pps_pkg::REG_RESET);
      reg_rd(12'h700, d);
      chk("unmapped read", d, 32'h0);
      reg_wr(pps_pkg::TARGET_SUBSECONDS_OFS, 32'hffff_ffff);
      reg_rd(pps_pkg::TARGET_SUBSECONDS_OFS, d);
      chk("target subseconds width", d, 32'h7fff_ffff);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_target;
      logic [31:0] d;
      reg_wr(pps_pkg::TARGET_SECONDS_OFS, 32'h5);
      reg_wr(pps_pkg::TARGET_SUBSECONDS_OFS, 32'ha);
      set_sec(32'h4, 31'h14);
      reg_wr(pps_pkg::EVENT_STATUS_OFS, 32'h3);
      reg_wr(pps_pkg::EVENT_MASK_OFS, 32'h2);
      reg_rd(pps_pkg::TIME_SYNC_STATUS_OFS, d);
      chk("below target", d, 32'h0);
      set_sec(32'h5, 31'h9);
      reg_rd(pps_pkg::TIME_SYNC_STATUS_OFS, d);
      chk("one count short", d, 32'h0);
      set_sec(32'h5, 31'ha);
      reg_rd(pps_pkg::TIME_SYNC_STATUS_OFS, d);
      chk("target reached", d, 32'h2);
      chk("target irq", {31'h0, irq}, 32'h1);
      reg_wr(pps_pkg::EVENT_STATUS_OFS, 32'h2);
      repeat (2) @(posedge sys_clk);
      reg_rd(pps_pkg::TIME_SYNC_STATUS_OFS, d);
      chk("hit cleared", d, 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      reg_wr(pps_pkg::TARGET_SECONDS_OFS, 32'hffff_ffff);
      reg_wr(pps_pkg::TARGET_SUBSECONDS_OFS, 32'h7fff_ffff);
      $display("test_target done");
   endtask : test_target

   task automatic test_wrap;
      logic [31:0] d;
      reg_wr(pps_pkg::EVENT_MASK_OFS, 32'h1);
      set_sec(32'hffff_ffff, 31'ha);
      chk("no early wrap irq", {31'h0, irq}, 32'h0);
      set_sec(32'h0, 31'h0);
      chk("wrap irq", {31'h0, irq}, 32'h1);
      reg_wr(pps_pkg::TIME_SYNC_STATUS_OFS, 32'h3);
      reg_rd(pps_pkg::TIME_SYNC_STATUS_OFS, d);
      chk("wrap flag read only", d, 32'h1);
      reg_wr(pps_pkg::EVENT_STATUS_OFS, 32'h1);
      repeat (2) @(posedge sys_clk);
      reg_rd(pps_pkg::TIME_SYNC_STATUS_OFS, d);
      chk("wrap flag cleared", d, 32'h0);
      chk("wrap irq low", {31'h0, irq}, 32'h0);
      $display("test_wrap done");
   endtask : test_wrap

   task automatic test_one_hz;
      step_sub(31'h0fff_ffff);
      chk("binary high end", {31'h0, pps_out}, 32'h1);
      step_sub(31'h1000_0000);
      chk("binary low start", {31'h0, pps_out}, 32'h0);
      // Digital rollover stays at 1 Hz, the only regular rate there
      @(posedge sys_clk);
      digital_rollover <= 1'b1;
      step_sub(31'h05f5_e0ff);
      chk("digital high end", {31'h0, pps_out}, 32'h1);
      step_sub(31'h05f5_e100);
      chk("digital low start", {31'h0, pps_out}, 32'h0);
      // Park low in both modes so the mode switch adds no pulse edge
      step_sub(31'h1000_0000);
      @(posedge sys_clk);
      digital_rollover <= 1'b0;
      $display("test_one_hz done");
   endtask : test_one_hz

   task automatic test_rates;
      logic [31:0] d;
      logic [15:0] start;
      logic [30:0] half;
      start = rise_count;
      for (int n = 1; n < 16; n++) begin
         half = 31'h1 << (30 - n);
         reg_wr_rd(pps_pkg::PULSE_OUTPUT_CONTROL_OFS, 32'(n), d);
         chk("rate select", d, 32'(n));
         step_sub(half - 31'h1);
         chk("first half low", {31'h0, pps_out}, 32'h0);
         step_sub(half);
         chk("second half high", {31'h0, pps_out}, 32'h1);
      end
      // Monitor scores the last rise one edge later
      @(posedge sys_clk);
      #1;
      chk("pulse rises", {16'h0, rise_count - start}, 32'h0000_000f);
      $display("test_rates done");
   endtask : test_rates

   // ------------------------------------------------------------
   // Sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      test_reset();
      test_target();
      test_wrap();
      test_one_hz();
      test_rates();
      end_sim();
   end

   initial begin
      repeat (50000) @(posedge sys_clk);
      mismatches++;
      end_sim();
   end
endmodule : tb_top
